/* hw/tism_defines.svh */
`ifndef TISM_DEFINES_SVH
`define TISM_DEFINES_SVH
// ==========================================================================
// transmission time interval codes (column count is 1 << code)
`define TISM_TTI_10MS 2'h0
`define TISM_TTI_20MS 2'h1
`define TISM_TTI_40MS 2'h2
`define TISM_TTI_80MS 2'h3
// ==========================================================================
// buffering and arithmetic constants
`define TISM_FIFO_DEPTH 16
`define TISM_PL_FRAC 8
`define TISM_Q_FRAC 3
`define TISM_TURBO_DIV 3
`define TISM_A_FULL 2'h2
`define TISM_A_HALF 2'h1
// ==========================================================================
// parity stream selectors for shift placement
`define TISM_STREAM_CONV 2'h0
`define TISM_STREAM_Y 2'h1
`define TISM_STREAM_Y2 2'h2
`endif

/* hw/tism_pkg.sv */
package tism_pkg;
   // ==========================================================================
   // types shared by the chain
   typedef enum logic [1:0] {TISM_IDLE, TISM_FILL, TISM_DRAIN} tism_state_e;
   typedef logic [1:0] tism_tti_t; // interval code, see defines
   // reverse the low tti bits of a column or frame index; the first
   // interleaver's column pattern is exactly this reversal, and it is its
   // own inverse, so the same function serves both directions
   function automatic logic [2:0] tism_bitrev(input logic [2:0] v, input tism_tti_t tti);
      logic [2:0] r;
      r = 3'h0;
      for (int b = 0; b < 3; b++)
      begin
         if (b < int'(tti))
         begin
            r[b] = v[int'(tti) - 1 - b];
         end
      end
      return r;
   endfunction
endpackage

/* hw/tism_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// small flop fifo between the interleaver read-out and the frame consumer
module tism_fifo #(
   parameter int W = 5,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready
);
   typedef struct packed {
      logic [DEPTH*W-1:0] mem; // storage words
      logic [AW-1:0] wr;       // write index
      logic [AW-1:0] rd;       // read index
      logic [AW:0] cnt;        // fill level
   } tism_fifo_s;
   tism_fifo_s s_q, s_d;
   logic push, pop;
   // ready and valid come from the fill level alone, so neither side loops
   assign o_in_ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign o_out_valid = (s_q.cnt != '0);
   assign o_out_data = s_q.mem[s_q.rd*W +: W];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   // ==========================================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wr*W +: W] = i_in_data;
         s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop)
      begin
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
      end
      if (push && !pop)
      begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end
   // state register, frozen while the clock enable is low
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         s_q <= '0;
      else if (i_ce)
         s_q <= s_d;
   end
   // ==========================================================================
   // checks
   property p_fifo_full;
      @(posedge i_mclk) disable iff (i_rst)
      (s_q.cnt == (AW+1)'(DEPTH)) |-> !o_in_ready;
   endproperty
   a_fifo_full: assert property (p_fifo_full) else $error("fifo full but ready");
   property p_fifo_grow;
      @(posedge i_mclk) disable iff (i_rst)
      (i_ce && push && !pop) |=> (s_q.cnt == $past(s_q.cnt) + 1'b1);
   endproperty
   a_fifo_grow: assert property (p_fifo_grow) else $error("fifo level did not grow");
endmodule
`default_nettype wire

/* hw/tism_rm_stream.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// pattern shift and error parameters for one coded stream and one frame
module tism_rm_stream
   import tism_pkg::*;
#(
   parameter int NW = 16,
   parameter int EW = 20
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [1:0] i_a,        // scaling factor
   input wire logic [NW-1:0] i_dn,    // magnitude of the bit delta
   input wire logic [NW-1:0] i_n,     // frame length used
   input wire tism_tti_t i_tti,
   input wire logic [2:0] i_frame,    // frame in the interval
   input wire logic [1:0] i_stream,   // conv, first or second parity
   input wire logic i_turbo_punct,
   output logic [EW-1:0] o_e_ini,
   output logic [EW-1:0] o_e_plus,
   output logic [EW-1:0] o_e_minus
);
   `include "tism_defines.svh"
   typedef struct packed {
      logic [EW-1:0] e_ini;
      logic [EW-1:0] e_plus;
      logic [EW-1:0] e_minus;
   } tism_rms_s;
   tism_rms_s s_q, s_d;
   assign o_e_ini = s_q.e_ini;
   assign o_e_plus = s_q.e_plus;
   assign o_e_minus = s_q.e_minus;
   // ==========================================================================
   // shift search then error terms; all combinational, one register stage
   always_comb
   begin
      logic [NW-1:0] q, lowbit, fcnt, g;
      logic [NW+3:0] q8, v, shift;
      logic [2:0] pos, r;
      logic [39:0] an, num;
      q = '0; lowbit = '0; g = '0; q8 = '0; v = '0; shift = '0;
      pos = '0; r = '0; an = '0; num = '0;
      fcnt = NW'(1) << i_tti;
      s_d = s_q;
      if (i_dn != '0)
      begin
         q = i_n / i_dn;
      end
      lowbit = q & (~q + 1'b1);
      g = (lowbit > fcnt) ? fcnt : lowbit;
      // q in eighths; even q gives up gcd(q,F)/F
      q8 = {q, 3'h0};
      if (!q[0])
      begin
         q8 = q8 - (NW+4)'(({g, 3'h0}) >> i_tti);
      end
      for (int x = 0; x < 8; x++)
      begin
         if (x < int'(fcnt))
         begin
            if (i_turbo_punct && q <= NW'(2))
            begin
               pos = 3'((3 * x) + int'(i_stream)) & 3'(fcnt - 1'b1);
               v = (NW+4)'(x % 2);
            end
            else
            begin
               v = (NW+4)'((q8 * (NW+4)'(x) + (NW+4)'(7)) >> `TISM_Q_FRAC);
               r = 3'(v) & 3'(fcnt - 1'b1);
               pos = (i_stream == `TISM_STREAM_CONV) ? r
                     : 3'((3 * int'(r)) + int'(i_stream)) & 3'(fcnt - 1'b1);
               v = v >> i_tti;
            end
            // the interleaving function is its own inverse here
            if (tism_bitrev(pos, i_tti) == i_frame)
            begin
               shift = v;
            end
         end
      end
      an = 40'(i_a) * 40'(i_n);
      num = 40'(i_a) * 40'(shift) * 40'(i_dn) + 40'(i_n);
      s_d.e_plus = EW'(an);
      s_d.e_minus = EW'(40'(i_a) * 40'(i_dn));
      // zero initial error is replaced by a full period
      if (an == '0)
         s_d.e_ini = '0;
      else if ((num % an) == '0)
         s_d.e_ini = EW'(an);
      else
         s_d.e_ini = EW'(num % an);
   end
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         s_q <= '0;
      else if (i_ce)
         s_q <= s_d;
   end
   // ==========================================================================
   // initial error always lies in 1..e_plus once a period exists
   property p_eini_range;
      @(posedge i_mclk) disable iff (i_rst)
      (s_q.e_plus != '0) |-> (s_q.e_ini != '0 && s_q.e_ini <= s_q.e_plus);
   endproperty
   a_eini_range: assert property (p_eini_range) else $error("initial error out of range");
endmodule
`default_nettype wire

/* hw/tism_top.sv */
// Summary of operation
// - columns 1,2,4,8 for 10,20,40,80 ms
// - rows equal block length over columns
// - matrix written row by row
// - columns permuted by the fixed patterns
// - matrix read out column by column
// - interleaved bits cut into equal segments
// - segment n goes out in frame n
// - interleaving function is its own inverse
// - cumulative weighted counts give per-channel delta
// - smallest capacity passing the puncture limit
// - delta evaluated from inputs latched once per interval
// - zero delta passes bits, no pattern
// - weights held constant, used in every delta
// - convolutional: factor 2, q and q-prime
// - frame shifts from ceil of x times q'
// - initial error, increment and decrement per frame
// - turbo repetition uses convolutional parameters
// - turbo puncturing splits delta, third of length
// - turbo shift placement at 3r+1, 3r+2
// - downstream loop subtracts decrement, adds increment
`timescale 1ns/100ps
`default_nettype none
module tism_top
   import tism_pkg::*;
#(
   parameter int NCH = 4,     // channels in the composite
   parameter int NCAP = 4,    // entries of the capacity set
   parameter int WW = 8,      // weight width
   parameter int NW = 16,     // bit count width
   parameter int EW = 20,     // error term width
   parameter int CW = 2,      // channel select width
   parameter int MAXB = 256,  // largest block in bits
   parameter int AW = 8       // bit index width
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire tism_tti_t i_tti,
   input wire logic [AW:0] i_block_len,
   input wire logic i_turbo,
   input wire logic [CW-1:0] i_chan_sel,
   input wire logic [NCH*WW-1:0] i_rate_match_weight,
   input wire logic [NCH*NW-1:0] i_frame_bits,
   input wire logic [7:0] i_puncture_limit,
   input wire logic [NCAP*NW-1:0] i_supported_capacity_set,
   input wire logic i_in_valid,
   input wire logic i_in_bit,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic o_out_bit,
   output logic [2:0] o_out_frame,
   output logic o_out_last,
   input wire logic i_out_ready,
   output logic [NW-1:0] o_capacity,
   output logic signed [NW+1:0] o_delta,
   output logic o_bypass,
   output logic o_puncture,
   output logic o_split,
   output logic [EW-1:0] o_e_ini,
   output logic [EW-1:0] o_e_plus,
   output logic [EW-1:0] o_e_minus,
   output logic [EW-1:0] o_e_ini2,
   output logic [EW-1:0] o_e_plus2,
   output logic [EW-1:0] o_e_minus2
);
   `include "tism_defines.svh"
   localparam int PW = WW + NW;       // weighted count width
   localparam int SW = PW + CW + 1;   // sum of weighted counts width
   // ==========================================================================
   // whole module state
   typedef struct packed {
      tism_state_e st;                // sequencer state
      logic rdy;                      // input ready
      logic [MAXB-1:0] mem;           // interleaver matrix, row-major
      logic [AW-1:0] wr;              // write index
      logic [AW:0] row;               // read row in current column
      logic [2:0] col;                // permuted column, equals frame
      tism_tti_t tti;                 // latched interval
      logic [AW:0] len;               // latched block length
      logic turbo;                    // latched code type
      logic [CW-1:0] sel;             // latched channel
      logic [NCH*WW-1:0] rmw;         // latched weights
      logic [NCH*NW-1:0] nbits;       // latched frame counts
      logic [7:0] pl;                 // latched puncture limit
      logic [NCAP*NW-1:0] caps;       // latched capacity set
      logic [NW-1:0] cap;             // chosen capacity
      logic signed [NW+1:0] delta;    // bit delta for this channel
      logic bypass;
      logic punct;
      logic split;
   } tism_top_s;
   localparam tism_top_s TISM_RST = '{st: TISM_IDLE, rdy: 1'b1, default: '0};
   tism_top_s s_q, s_d;
   // fifo and pipeline wires
   logic push, fifo_rdy;
   logic [4:0] push_data, head_data;
   logic [AW-1:0] rd_addr;
   logic [AW:0] ylen_m1;
   logic [2:0] cmax;
   // rate-match arithmetic wires
   logic [SW-1:0] total, cum_sel, cum_prev;
   logic [WW-1:0] minrm;
   logic [NW-1:0] cap_c, n_sel, mag, dn1, dn2, nn1, nn2;
   logic signed [NW+1:0] delta_c;
   logic tp;
   logic [1:0] a2, st2;
   // ==========================================================================
   // read-out addressing
   // segment length equals row count, so each permuted column is one frame
   assign ylen_m1 = (s_q.len >> s_q.tti) - 1'b1;
   assign cmax = 3'((4'h1 << s_q.tti) - 1'b1);
   // original column of permuted column col is its bit reversal
   assign rd_addr = AW'((AW+3)'(s_q.row) << s_q.tti) | AW'(tism_bitrev(s_q.col, s_q.tti));
   assign push = (s_q.st == TISM_DRAIN);
   assign push_data = {s_q.mem[rd_addr], s_q.col, (s_q.row == ylen_m1)};
   assign o_in_ready = s_q.rdy;
   assign o_out_bit = head_data[4];
   assign o_out_frame = head_data[3:1];
   assign o_out_last = head_data[0];
   assign o_capacity = s_q.cap;
   assign o_delta = s_q.delta;
   assign o_bypass = s_q.bypass;
   assign o_puncture = s_q.punct;
   assign o_split = s_q.split;
   // ==========================================================================
   // weighted sums, capacity choice and channel delta
   always_comb
   begin
      logic [SW-1:0] acc;
      logic [SW+7:0] need;
      logic [NW-1:0] cv;
      logic [NW+WW+`TISM_PL_FRAC-1:0] have;
      logic [SW+NW-1:0] zs, zp;
      logic found;
      acc = '0; need = '0; cv = '0; have = '0; zs = '0; zp = '0; found = 1'b0;
      cum_sel = '0; cum_prev = '0;
      minrm = {WW{1'b1}};
      cap_c = '0;
      for (int i = 0; i < NCH; i++)
      begin
         // weights enter every delta, only latched at interval start
         // widen both factors first so the product keeps all its bits
         acc = acc + SW'(s_q.rmw[i*WW +: WW]) * SW'(s_q.nbits[i*NW +: NW]);
         if (i < int'(s_q.sel))
            cum_prev = acc;
         if (i == int'(s_q.sel))
            cum_sel = acc;
         if (s_q.rmw[i*WW +: WW] < minrm)
            minrm = s_q.rmw[i*WW +: WW];
      end
      total = acc;
      // scale by min weight instead of dividing, keeps it integer
      need = (SW+8)'(s_q.pl) * (SW+8)'(total);
      for (int c = 0; c < NCAP; c++)
      begin
         cv = s_q.caps[c*NW +: NW];
         have = (NW+WW+`TISM_PL_FRAC)'((NW+WW)'(cv) * (NW+WW)'(minrm)) << `TISM_PL_FRAC;
         if ((SW+8)'(have) >= need && (!found || cv < cap_c))
         begin
            cap_c = cv;
            found = 1'b1;
         end
      end
      // no entry qualifies: fall back to the largest one
      if (!found)
      begin
         for (int c = 0; c < NCAP; c++)
            if (s_q.caps[c*NW +: NW] > cap_c)
               cap_c = s_q.caps[c*NW +: NW];
      end
      if (total != '0)
      begin
         zs = ((SW+NW)'(cum_sel) * (SW+NW)'(cap_c)) / (SW+NW)'(total);
         zp = ((SW+NW)'(cum_prev) * (SW+NW)'(cap_c)) / (SW+NW)'(total);
      end
      n_sel = s_q.nbits[s_q.sel*NW +: NW];
      delta_c = (NW+2)'(zs) - (NW+2)'(zp) - (NW+2)'(n_sel);
   end
   // ==========================================================================
   // per-stream factor, delta and length
   always_comb
   begin
      mag = NW'(s_q.delta < 0 ? -s_q.delta : s_q.delta);
      tp = s_q.turbo && (s_q.delta < 0);
      dn1 = tp ? NW'((NW+1)'(mag) + 1'b1 >> 1) : mag;
      dn2 = tp ? (mag >> 1) : mag;
      nn1 = tp ? NW'(n_sel / `TISM_TURBO_DIV) : n_sel;
      nn2 = nn1;
      a2 = tp ? `TISM_A_HALF : `TISM_A_FULL;
      st2 = tp ? `TISM_STREAM_Y2 : `TISM_STREAM_CONV;
   end
   // ==========================================================================
   // sequencer: fill row-major, drain column-major into the fifo
   always_comb
   begin
      s_d = s_q;
      case (s_q.st)
         TISM_IDLE:
         begin
            // configuration is taken with the first bit of an interval
            if (i_in_valid)
            begin
               s_d.tti = i_tti;
               s_d.len = i_block_len;
               s_d.turbo = i_turbo;
               s_d.sel = i_chan_sel;
               s_d.rmw = i_rate_match_weight;
               s_d.nbits = i_frame_bits;
               s_d.pl = i_puncture_limit;
               s_d.caps = i_supported_capacity_set;
               s_d.mem[0] = i_in_bit;
               s_d.wr = AW'(1);
               s_d.row = '0;
               s_d.col = '0;
               s_d.st = (i_block_len <= (AW+1)'(1)) ? TISM_DRAIN : TISM_FILL;
            end
         end
         TISM_FILL:
         begin
            // one bit per enabled clock while valid
            if (i_in_valid)
            begin
               s_d.mem[s_q.wr] = i_in_bit;
               s_d.wr = s_q.wr + 1'b1;
               if ((AW+1)'(s_q.wr) == s_q.len - 1'b1)
                  s_d.st = TISM_DRAIN;
            end
         end
         TISM_DRAIN:
         begin
            // stall here while the fifo is full
            if (fifo_rdy)
            begin
               if (s_q.row == ylen_m1)
               begin
                  s_d.row = '0;
                  if (s_q.col == cmax)
                     s_d.st = TISM_IDLE;
                  else
                     s_d.col = s_q.col + 1'b1;
               end
               else
               begin
                  s_d.row = s_q.row + 1'b1;
               end
            end
         end
         default:
         begin
            s_d.st = TISM_IDLE;
         end
      endcase
      s_d.rdy = (s_d.st != TISM_DRAIN);
      // parameters refreshed every cycle from the latched configuration, so each new interval gets its own
      s_d.cap = cap_c;
      s_d.delta = delta_c;
      s_d.bypass = (delta_c == '0);
      s_d.punct = (delta_c < 0);
      s_d.split = s_q.turbo && (delta_c < 0);
   end
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         s_q <= TISM_RST;
      else if (i_ce)
         s_q <= s_d;
   end
   // ==========================================================================
   // sub-blocks: frame fifo and the two stream parameter engines
   tism_fifo #(.W(5), .DEPTH(`TISM_FIFO_DEPTH), .AW(4)) u_fifo (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_in_valid(push),
      .i_in_data(push_data),
      .o_in_ready(fifo_rdy),
      .o_out_valid(o_out_valid),
      .o_out_data(head_data),
      .i_out_ready(i_out_ready)
   );
   // parameters follow the frame at the fifo head, one cycle behind it
   tism_rm_stream #(.NW(NW), .EW(EW)) u_rm_y (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_a(`TISM_A_FULL),
      .i_dn(dn1),
      .i_n(nn1),
      .i_tti(s_q.tti),
      .i_frame(head_data[3:1]),
      .i_stream(tp ? `TISM_STREAM_Y : `TISM_STREAM_CONV),
      .i_turbo_punct(tp),
      .o_e_ini(o_e_ini),
      .o_e_plus(o_e_plus),
      .o_e_minus(o_e_minus)
   );
   tism_rm_stream #(.NW(NW), .EW(EW)) u_rm_y2 (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_a(a2),
      .i_dn(dn2),
      .i_n(nn2),
      .i_tti(s_q.tti),
      .i_frame(head_data[3:1]),
      .i_stream(st2),
      .i_turbo_punct(tp),
      .o_e_ini(o_e_ini2),
      .o_e_plus(o_e_plus2),
      .o_e_minus(o_e_minus2)
   );
   // ==========================================================================
   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   property p_col_range;
      (s_q.st == TISM_DRAIN) |-> (s_q.col <= cmax);
   endproperty
   a_col_range: assert property (p_col_range) else $error("column beyond count");
   property p_row_wrap;
      (i_ce && push && fifo_rdy && s_q.row == ylen_m1) |=> (s_q.row == '0);
   endproperty
   a_row_wrap: assert property (p_row_wrap) else $error("row did not wrap");
   property p_fill_order;
      (i_ce && s_q.st == TISM_FILL && i_in_valid) |=> (s_q.wr == AW'($past(s_q.wr) + 1'b1));
   endproperty
   a_fill_order: assert property (p_fill_order) else $error("write index skipped");
   property p_perm80;
      (push && s_q.tti == `TISM_TTI_80MS && s_q.col == 3'h1 && s_q.row == '0)
         |-> (rd_addr == AW'(4));
   endproperty
   a_perm80: assert property (p_perm80) else $error("column pattern wrong");
   property p_frame_tag;
      push |-> (push_data[3:1] == s_q.col);
   endproperty
   a_frame_tag: assert property (p_frame_tag) else $error("frame tag wrong");
   sequence s_last_fill;
      i_ce && s_q.st == TISM_FILL && i_in_valid && (AW+1)'(s_q.wr) == s_q.len - 1'b1;
   endsequence
   sequence s_drain_start;
      s_q.st == TISM_DRAIN && !o_in_ready && s_q.row == '0 && s_q.col == 3'h0;
   endsequence
   property p_fill_to_drain;
      s_last_fill |=> s_drain_start;
   endproperty
   a_fill_to_drain: assert property (p_fill_to_drain) else $error("drain did not start");
   property p_cfg_hold;
      (s_q.st != TISM_IDLE) |=> ($stable(s_q.tti) && $stable(s_q.rmw));
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config moved mid interval");
endmodule
`default_nettype wire

/* tb/tism_sink.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// downstream consumer model: takes bits at once or stalls every other cycle
module tism_sink (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_slow, // stall mode
   output logic o_ready
);
   // ready moves just after the edge so it is stable for a whole cycle
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_ready <= 1'b0;
      end
      else
      begin
         o_ready <= i_slow ? ~o_ready : 1'b1;
      end
   end
endmodule
`default_nettype wire

/* tb/tism_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module tism_top_test;
   import tism_pkg::*;
   // ==========================================================================
   // stimulus and observed signals
   logic clk = 1'b0;
   logic rst, vld, bt, slow, rdy, in_rdy, ov, ob, olast, byp, pun;
   tism_tti_t tti;
   logic [2:0] ofr;
   logic [15:0] capo;
   logic signed [17:0] dlt;
   logic [19:0] e1, e2, e3, f1, f2, f3;
   logic turbo, spl;
   logic [63:0] cap;
   logic [15:0] pat = 16'h4b3d; // input bit k is pat[k]
   int error_cnt = 0;
   int checks = 0;
   always #2.5 clk = ~clk;
   tism_sink i_sink (.i_mclk(clk), .i_rst(rst), .i_slow(slow), .o_ready(rdy));
   tism_top i_dut (.i_mclk(clk), .i_rst(rst), .i_ce(1'b1), .i_tti(tti),
      .i_block_len(9'h010), .i_turbo(turbo), .i_chan_sel(2'h0),
      .i_rate_match_weight({4{8'h01}}), .i_frame_bits({4{16'h0032}}),
      .i_puncture_limit(8'h00), .i_supported_capacity_set(cap),
      .i_in_valid(vld), .i_in_bit(bt), .o_in_ready(in_rdy), .o_out_valid(ov),
      .o_out_bit(ob), .o_out_frame(ofr), .o_out_last(olast), .i_out_ready(rdy),
      .o_capacity(capo), .o_delta(dlt), .o_bypass(byp), .o_puncture(pun),
      .o_split(spl), .o_e_ini(e1), .o_e_plus(e2), .o_e_minus(e3), .o_e_ini2(f1),
      .o_e_plus2(f2), .o_e_minus2(f3));
   // ==========================================================================
   // compare and report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // our own index reversal, kept apart from the design's helper
   function automatic int flip(input int v, input int t);
      int o;
      o = 0;
      for (int b = 0; b < t; b++)
         if (v[b]) o |= 1 << (t - 1 - b);
      return o;
   endfunction
   // ==========================================================================
   // one 16-bit block in, every output bit, frame and last flag checked
   task automatic run_block(input int t);
      int c, rr, k, w, n, r;
      c = 1 << t;
      rr = 16 / c;
      for (k = 0; k < 16; k++)
      begin
         @(negedge clk);
         tti = t[1:0];
         vld = 1'b1;
         bt = pat[k];
      end
      @(negedge clk);
      vld = 1'b0;
      chk("in_ready_low", in_rdy, 1'b0);
      k = 0;
      w = 0;
      // a pop happens at the next rising edge when both are high here
      while (k < 16 && w < 500)
      begin
         @(negedge clk);
         w++;
         if (ov === 1'b1 && rdy === 1'b1)
         begin
            n = k / rr;
            r = k % rr;
            chk("out_bit", ob, pat[r * c + flip(n, t)]);
            chk("out_frame", ofr, n);
            chk("out_last", olast, r == rr - 1);
            k++;
         end
      end
      chk("bits_out", k, 16);
      repeat (3) @(negedge clk);
      chk("in_ready_idle", in_rdy, 1'b1);
   endtask
   // ==========================================================================
   // main sequence
   initial
   begin
      rst = 1'b1;
      vld = 1'b0;
      bt = 1'b0;
      slow = 1'b0;
      turbo = 1'b0;
      tti = 2'h0;
      cap = {16'h0190, 16'h00f0, 16'h0064, 16'h012c};
      repeat (10) @(negedge clk);
      rst = 1'b0;
      // four equal channels of 50 bits, smallest capacity 100 wins
      run_block(0);
      chk("capacity", capo, 32'h64);
      chk("delta", 32'(dlt), 32'hffffffe7);
      chk("puncture", pun, 1'b1);
      chk("e_ini", e1, 32'h32);
      chk("e_plus", e2, 32'h64);
      chk("e_minus", e3, 32'h32);
      // capacity equal to the load gives no delta
      cap = {4{16'h00c8}};
      run_block(0);
      chk("delta_zero", 32'(dlt), 32'h0);
      chk("bypass", byp, 1'b1);
      // turbo puncturing: delta -25 split 13/12 over a third of 50 bits
      cap = {16'h0190, 16'h00f0, 16'h0064, 16'h012c};
      turbo = 1'b1;
      run_block(0);
      chk("split", spl, 1'b1);
      chk("y_e_ini", e1, 32'h10);
      chk("y_e_plus", e2, 32'h20);
      chk("y_e_minus", e3, 32'h1a);
      chk("y2_e_ini", f1, 32'h10);
      chk("y2_e_plus", f2, 32'h10);
      chk("y2_e_minus", f3, 32'hc);
      turbo = 1'b0;
      cap = {4{16'h00c8}};
      for (int t = 1; t < 4; t++)
      begin
         slow = t[0];
         run_block(t);
      end
      end_of_test();
   end
   // watchdog well past the expected few hundred cycles
   initial
   begin
      #100000;
      error_cnt++;
      end_of_test();
   end
endmodule
`default_nettype wire
